// ### rtl/e1tsm_pkg.sv
// constants, field layouts and carrier types for the e1 time-slot monitor
// assumes the apb slave and both capture units share one clock
package e1tsm_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam int         E1TSM_ADDR_W   = 8;
  localparam logic [5:0] IDX_TX_SEL     = 6'h14;
  localparam logic [5:0] IDX_RX_SEL     = 6'h15;
  localparam logic [5:0] IDX_TX_SNAP    = 6'h22;
  localparam logic [5:0] IDX_RX_SNAP    = 6'h2A;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SEL_MSB         = 4;
  localparam int SEL_LSB         = 0;
  localparam int REMOTE_LOOP_BIT = 7;
  localparam int LOCAL_LOOP_BIT  = 6;
  localparam int LINE_ALARM_BIT  = 5;
  localparam int LINE_RST_BIT    = 7;
  localparam int EL_ALIGN_BIT    = 6;
  localparam int EL_RST_BIT      = 5;

  // ************************************************************
  // reset values and frame timing
  // ************************************************************
  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam logic [7:0] RX_CTRL_RST = 8'h00;
  localparam logic [7:0] SNAP_RST    = 8'h00;
  localparam logic [2:0] SLOT_LAST   = 3'h7;
  localparam logic [2:0] SLOT_FIRST  = 3'h0;

  // ************************************************************
  // carrier and state types
  // ************************************************************
  typedef struct packed {
    logic frame_start;
    logic bit_en;
    logic data;
  } e1tsm_stream_t;

  typedef struct packed {
    logic       aligned;
    logic [7:0] pos;
    logic       active;
    logic [7:0] shift;
    logic [7:0] snap;
    logic       upd;
  } e1tsm_cap_t;

  typedef struct packed {
    logic [7:0]  tx_ctrl;
    logic [7:0]  rx_ctrl;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  tx_prbs;
    logic [4:0]  rx_prbs;
  } e1tsm_top_t;

endpackage

// ### rtl/e1tsm_capture.sv
// one direction of the time-slot monitor: follows the frame and grabs one octet
// assumes bit_en strobes once per line bit and frame_start marks bit 0 of slot 0
`timescale 1ns/1ps
module e1tsm_capture
  import e1tsm_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // framer stream and slot select
  input  wire e1tsm_stream_t strm,
  input  wire logic [4:0]    sel,
  // captured octet
  output logic [7:0]         snap,
  output logic               upd
);

  e1tsm_cap_t s_reg;
  e1tsm_cap_t s_next;
  logic [7:0] pos_cur;
  logic       hit;
  logic       act;

  // ************************************************************
  // frame position, slot match and shifting
  // ************************************************************
  always_comb begin
    s_next  = s_reg;
    pos_cur = strm.frame_start ? 8'h00 : 8'(s_reg.pos + 8'h01);
    hit     = (strm.frame_start || s_reg.aligned) && (pos_cur[7:3] == sel);
    act     = (pos_cur[2:0] == SLOT_FIRST) ? hit : s_reg.active;
    s_next.upd = 1'b0;
    if (strm.bit_en) begin
      s_next.pos    = pos_cur;
      s_next.active = act;
      if (strm.frame_start) begin
        s_next.aligned = 1'b1;
      end
      if (act) begin
        s_next.shift = {s_reg.shift[6:0], strm.data};
      end
      if (act && pos_cur[2:0] == SLOT_LAST) begin
        s_next.snap = {s_reg.shift[6:0], strm.data};
        s_next.upd  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '{default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign snap = s_reg.snap;
  assign upd  = s_reg.upd;

  // ************************************************************
  // checks
  // ************************************************************
  property p_byte_order;
    @(posedge clk) disable iff (!nrst)
      upd |-> (snap[0] == $past(strm.data)) && (snap[7:1] == $past(s_reg.shift[6:0]));
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("octet bit order wrong");

  property p_update_point;
    @(posedge clk) disable iff (!nrst)
      upd |-> (s_reg.pos[2:0] == SLOT_LAST) && $past(s_reg.active) && $past(strm.bit_en);
  endproperty
  a_update_point: assert property (p_update_point) else $error("update not at slot end");

  property p_snap_hold;
    @(posedge clk) disable iff (!nrst)
      !upd |-> $stable(snap);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("octet changed without update");

endmodule // e1tsm_capture

// ### rtl/e1tsm_top.sv
// apb register slave and two time-slot capture units of one framer
// assumes both framer streams are synchronous to REF_CLK
`timescale 1ns/1ps
module e1tsm_top
  import e1tsm_pkg::*;
#(
  parameter int ADDR_W = E1TSM_ADDR_W
) (
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // framer streams
  input  wire e1tsm_stream_t     TX_STREAM,
  input  wire e1tsm_stream_t     RX_STREAM,
  // test pattern mode
  input  wire logic              TX_PRBS_SINGLE_SLOT,
  input  wire logic              RX_PRBS_SINGLE_SLOT,
  output logic      [4:0]        TX_PRBS_SLOT,
  output logic      [4:0]        RX_PRBS_SLOT,
  // control bits to the framer
  output logic                   REMOTE_LOOP_ENABLE,
  output logic                   LOCAL_LOOP_ENABLE,
  output logic                   LINE_ALARM_GEN_ENABLE,
  output logic                   LINE_INTERFACE_RESET,
  output logic                   RX_ELASTIC_ALIGN,
  output logic                   RX_ELASTIC_RESET
);

  // ************************************************************
  // declarations
  // ************************************************************
  e1tsm_top_t s_reg;
  e1tsm_top_t s_next;
  logic [7:0] tx_snap;
  logic [7:0] rx_snap;
  logic       tx_upd;
  logic       rx_upd;
  logic       setup;
  logic       done;
  logic       wr_done;
  logic [5:0] idx;
  logic       word_ok;
  logic       mapped;
  logic [7:0] rd_byte;

  // ************************************************************
  // capture units, one per direction
  // ************************************************************
  e1tsm_capture u_tx_cap (
    .clk  (REF_CLK),
    .nrst (NRST),
    .strm (TX_STREAM),
    .sel  (s_reg.tx_ctrl[SEL_MSB:SEL_LSB]),
    .snap (tx_snap),
    .upd  (tx_upd)
  );

  e1tsm_capture u_rx_cap (
    .clk  (REF_CLK),
    .nrst (NRST),
    .strm (RX_STREAM),
    .sel  (s_reg.rx_ctrl[SEL_MSB:SEL_LSB]),
    .snap (rx_snap),
    .upd  (rx_upd)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  always_comb begin
    idx     = PADDR[7:2];
    word_ok = (PADDR[1:0] == 2'h0);
    setup   = PSEL && !PENABLE;
    done    = PSEL && PENABLE && s_reg.pready;
    wr_done = done && PWRITE && !s_reg.pslverr && PSTRB[0];
    mapped  = 1'b0;
    rd_byte = 8'h00;
    if (word_ok) begin
      case (idx)
        IDX_TX_SEL: begin
          mapped  = 1'b1;
          rd_byte = s_reg.tx_ctrl;
        end
        IDX_RX_SEL: begin
          mapped  = 1'b1;
          rd_byte = s_reg.rx_ctrl;
        end
        IDX_TX_SNAP: begin
          mapped  = 1'b1;
          rd_byte = tx_snap;
        end
        IDX_RX_SNAP: begin
          mapped  = 1'b1;
          rd_byte = rx_snap;
        end
        default: begin
          mapped  = 1'b0;
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_next        = s_reg;
    s_next.pready = setup;
    if (setup) begin
      s_next.prdata  = {24'h000000, rd_byte};
      s_next.pslverr = !mapped;
    end
    if (wr_done && word_ok) begin
      case (idx)
        IDX_TX_SEL: begin
          s_next.tx_ctrl = PWDATA[7:0];
        end
        IDX_RX_SEL: begin
          s_next.rx_ctrl = PWDATA[7:0];
        end
        default: begin
          s_next.tx_ctrl = s_reg.tx_ctrl;
        end
      endcase
    end
    s_next.tx_prbs = TX_PRBS_SINGLE_SLOT ? s_reg.tx_ctrl[SEL_MSB:SEL_LSB] : 5'h00;
    s_next.rx_prbs = RX_PRBS_SINGLE_SLOT ? s_reg.rx_ctrl[SEL_MSB:SEL_LSB] : 5'h00;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      s_reg.tx_ctrl <= TX_CTRL_RST;
      s_reg.rx_ctrl <= RX_CTRL_RST;
      s_reg.prdata  <= 32'h00000000;
      s_reg.pready  <= 1'b0;
      s_reg.pslverr <= 1'b0;
      s_reg.tx_prbs <= 5'h00;
      s_reg.rx_prbs <= 5'h00;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign PRDATA                = s_reg.prdata;
  assign PREADY                = s_reg.pready;
  assign PSLVERR               = s_reg.pslverr;
  assign TX_PRBS_SLOT          = s_reg.tx_prbs;
  assign RX_PRBS_SLOT          = s_reg.rx_prbs;
  assign REMOTE_LOOP_ENABLE    = s_reg.tx_ctrl[REMOTE_LOOP_BIT];
  assign LOCAL_LOOP_ENABLE     = s_reg.tx_ctrl[LOCAL_LOOP_BIT];
  assign LINE_ALARM_GEN_ENABLE = s_reg.tx_ctrl[LINE_ALARM_BIT];
  assign LINE_INTERFACE_RESET  = s_reg.rx_ctrl[LINE_RST_BIT];
  assign RX_ELASTIC_ALIGN      = s_reg.rx_ctrl[EL_ALIGN_BIT];
  assign RX_ELASTIC_RESET      = s_reg.rx_ctrl[EL_RST_BIT];

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  sequence s_access;
    PSEL && PENABLE && PREADY;
  endsequence

  property p_ready_pulse;
    @(posedge REF_CLK) disable iff (!NRST)
      s_setup |=> PREADY ##1 !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready not one cycle");

  property p_tx_sel_write;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && PSTRB[0] && PADDR == {IDX_TX_SEL, 2'h0}))
      |=> s_reg.tx_ctrl[SEL_MSB:SEL_LSB] == $past(PWDATA[4:0]);
  endproperty
  a_tx_sel_write: assert property (p_tx_sel_write) else $error("tx select not stored");

  property p_rx_sel_write;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && PSTRB[0] && PADDR == {IDX_RX_SEL, 2'h0}))
      |=> s_reg.rx_ctrl[SEL_MSB:SEL_LSB] == $past(PWDATA[4:0]);
  endproperty
  a_rx_sel_write: assert property (p_rx_sel_write) else $error("rx select not stored");

  property p_tx_snap_read;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_setup and (PADDR == {IDX_TX_SNAP, 2'h0}))
      |=> PREADY && PRDATA == {24'h000000, $past(tx_snap)};
  endproperty
  a_tx_snap_read: assert property (p_tx_snap_read) else $error("tx octet read wrong");

  property p_rx_snap_read;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_setup and (PADDR == {IDX_RX_SNAP, 2'h0}))
      |=> PREADY && PRDATA == {24'h000000, $past(rx_snap)};
  endproperty
  a_rx_snap_read: assert property (p_rx_snap_read) else $error("rx octet read wrong");

  property p_snap_write_ignored;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && (PADDR == {IDX_TX_SNAP, 2'h0} || PADDR == {IDX_RX_SNAP, 2'h0})))
      |=> $stable(s_reg.tx_ctrl) && $stable(s_reg.rx_ctrl) && !PSLVERR;
  endproperty
  a_snap_write_ignored: assert property (p_snap_write_ignored) else $error("octet write had effect");

  property p_tx_ctrl_bits;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && PSTRB[0] && PADDR == {IDX_TX_SEL, 2'h0}))
      |=> REMOTE_LOOP_ENABLE == $past(PWDATA[7]) && LOCAL_LOOP_ENABLE == $past(PWDATA[6])
          && LINE_ALARM_GEN_ENABLE == $past(PWDATA[5]);
  endproperty
  a_tx_ctrl_bits: assert property (p_tx_ctrl_bits) else $error("tx control bits wrong");

  property p_rx_ctrl_bits;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && PSTRB[0] && PADDR == {IDX_RX_SEL, 2'h0}))
      |=> LINE_INTERFACE_RESET == $past(PWDATA[7]) && RX_ELASTIC_ALIGN == $past(PWDATA[6])
          && RX_ELASTIC_RESET == $past(PWDATA[5]);
  endproperty
  a_rx_ctrl_bits: assert property (p_rx_ctrl_bits) else $error("rx control bits wrong");

  property p_prbs_slot;
    @(posedge REF_CLK) disable iff (!NRST)
      ##1 TX_PRBS_SLOT == ($past(TX_PRBS_SINGLE_SLOT) ? $past(s_reg.tx_ctrl[4:0]) : 5'h00);
  endproperty
  a_prbs_slot: assert property (p_prbs_slot) else $error("test slot select wrong");

  property p_independent;
    @(posedge REF_CLK) disable iff (!NRST)
      (tx_upd && !rx_upd) |-> $stable(rx_snap);
  endproperty
  a_independent: assert property (p_independent) else $error("directions not independent");

  property p_unmapped;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_setup and (PADDR[1:0] != 2'h0)) |=> PREADY && PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("misaligned access not refused");

  property p_rx_prbs_slot;
    @(posedge REF_CLK) disable iff (!NRST)
      ##1 RX_PRBS_SLOT == ($past(RX_PRBS_SINGLE_SLOT) ? $past(s_reg.rx_ctrl[4:0]) : 5'h00);
  endproperty
  a_rx_prbs_slot: assert property (p_rx_prbs_slot) else $error("rx test slot select wrong");

  property p_strobe_masked;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_access and (PWRITE && !PSTRB[0])) |=> $stable(s_reg.tx_ctrl) && $stable(s_reg.rx_ctrl);
  endproperty
  a_strobe_masked: assert property (p_strobe_masked) else $error("masked write took effect");

  property p_ctrl_hold;
    @(posedge REF_CLK) disable iff (!NRST)
      !(PSEL && PENABLE && PREADY && PWRITE) |=> $stable(s_reg.tx_ctrl) && $stable(s_reg.rx_ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  property p_refused_read;
    @(posedge REF_CLK) disable iff (!NRST)
      (s_setup and (PADDR[1:0] == 2'h0 && !mapped)) |=> PREADY && PSLVERR && PRDATA == 32'h00000000;
  endproperty
  a_refused_read: assert property (p_refused_read) else $error("unmapped access not refused");

  property p_answer_hold;
    @(posedge REF_CLK) disable iff (!NRST)
      !(PSEL && !PENABLE) |=> $stable(PRDATA) && $stable(PSLVERR);
  endproperty
  a_answer_hold: assert property (p_answer_hold) else $error("answer changed without setup");

  property p_upper_zero;
    @(posedge REF_CLK) disable iff (!NRST)
      PREADY |-> PRDATA[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero");

endmodule // e1tsm_top

// ### sim/e1tsm_framer_model.sv
// framer stream model: sends a fixed octet table in every slot of both directions
// assumes one clock shared with the monitor; slow halves the bit rate
`timescale 1ns/1ps
module e1tsm_framer_model
  import e1tsm_pkg::*;
(
  // clock and reset
  input  wire logic    clk,
  input  wire logic    nrst,
  // pacing and octet tables
  input  wire logic    slow,
  input  wire logic [7:0] tx_oct [32],
  input  wire logic [7:0] rx_oct [32],
  // streams
  output e1tsm_stream_t tx,
  output e1tsm_stream_t rx
);
  logic [7:0] pos_reg;
  logic [7:0] rpos;
  logic       ph_reg;
  assign rpos = pos_reg + 8'h40;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pos_reg <= 8'h00;
      ph_reg  <= 1'b0;
      tx      <= '0;
      rx      <= '0;
    end else begin
      ph_reg <= slow & ~ph_reg;
      if (!ph_reg) begin
        pos_reg <= pos_reg + 8'h01;
        tx <= '{pos_reg == 8'h00, 1'b1, tx_oct[pos_reg[7:3]][3'h7 - pos_reg[2:0]]};
        rx <= '{rpos == 8'h00, 1'b1, rx_oct[rpos[7:3]][3'h7 - rpos[2:0]]};
      end else begin
        tx <= '{1'b0, 1'b0, ~tx.data};
        rx <= '{1'b0, 1'b0, ~rx.data};
      end
    end
  end
endmodule // e1tsm_framer_model

// ### sim/e1_timeslot_monitor_tb_top.sv
// testbench of the time-slot monitor: apb master, scoreboard queue, framer model
// assumes the apb slave answers without a fixed wait count
`timescale 1ns/1ps
module e1_timeslot_monitor_tb_top;
  import e1tsm_pkg::*;
  logic          REF_CLK = 1'b0;
  logic          NRST = 1'b0;
  logic          PSEL = 1'b0;
  logic          PENABLE = 1'b0;
  logic          PWRITE = 1'b0;
  logic [7:0]    PADDR = 8'h00;
  logic [31:0]   PWDATA = 32'h0;
  logic [3:0]    PSTRB = 4'hF;
  logic [31:0]   PRDATA;
  logic          PREADY;
  logic          PSLVERR;
  e1tsm_stream_t TX_STREAM;
  e1tsm_stream_t RX_STREAM;
  logic          TX_MODE = 1'b0;
  logic          RX_MODE = 1'b0;
  logic [4:0]    TX_SLOT;
  logic [4:0]    RX_SLOT;
  logic [2:0]    tx_bits;
  logic [2:0]    rx_bits;
  logic          slow = 1'b0;
  logic [7:0]    tx_o [32];
  logic [7:0]    rx_o [32];
  logic [33:0]   notes [$];
  int            miscompares = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  always #5 REF_CLK = ~REF_CLK;
  e1tsm_top dut (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TX_STREAM(TX_STREAM), .RX_STREAM(RX_STREAM), .TX_PRBS_SINGLE_SLOT(TX_MODE),
    .RX_PRBS_SINGLE_SLOT(RX_MODE), .TX_PRBS_SLOT(TX_SLOT), .RX_PRBS_SLOT(RX_SLOT),
    .REMOTE_LOOP_ENABLE(tx_bits[2]), .LOCAL_LOOP_ENABLE(tx_bits[1]), .LINE_ALARM_GEN_ENABLE(tx_bits[0]),
    .LINE_INTERFACE_RESET(rx_bits[2]), .RX_ELASTIC_ALIGN(rx_bits[1]), .RX_ELASTIC_RESET(rx_bits[0]));
  e1tsm_framer_model u_model (.clk(REF_CLK), .nrst(NRST), .slow(slow), .tx_oct(tx_o), .rx_oct(rx_o),
    .tx(TX_STREAM), .rx(RX_STREAM));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles >= 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // scoreboard: the answer is taken at the rising edge that samples ready high
  always @(posedge REF_CLK) begin
    logic [33:0] n;
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'hFFFFFFFF, 32'h0);
      end else begin
        n = notes.pop_front();
        check({31'h0, PSLVERR}, {31'h0, n[0]});
        if (n[33]) check(PRDATA, n[32:1]);
      end
    end
  end
  // ************************************************************
  // apb master
  // ************************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    notes.push_back({~w, e});
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    logic [4:0] s;
    logic [4:0] r;
    logic [2:0] c;
    logic       m;
    logic [7:0] ts;
    logic [7:0] rs;
    logic [7:0] tn;
    logic [7:0] rn;
    ts = {IDX_TX_SEL, 2'b00};
    rs = {IDX_RX_SEL, 2'b00};
    tn = {IDX_TX_SNAP, 2'b00};
    rn = {IDX_RX_SNAP, 2'b00};
    void'($urandom(32'hE92B));
    for (int i = 0; i < 32; i++) begin
      tx_o[i] = 8'($urandom);
      rx_o[i] = 8'($urandom);
    end
    repeat (3) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, ts, 32'h0, {24'h0, TX_CTRL_RST, 1'b0});
    apb(1'b0, rs, 32'h0, {24'h0, RX_CTRL_RST, 1'b0});
    for (int k = 0; k < 6; k++) begin
      s = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : 5'($urandom);
      r = (k == 0) ? 5'h1F : (k == 1) ? 5'h00 : 5'($urandom);
      c = 3'($urandom);
      m = 1'($urandom);
      slow <= k[0];
      TX_MODE <= m;
      RX_MODE <= ~m;
      apb(1'b1, ts, {24'h0, c, s}, 33'h0);
      apb(1'b1, rs, {24'h0, ~c, r}, 33'h0);
      apb(1'b0, ts, 32'h0, {24'h0, c, s, 1'b0});
      @(negedge REF_CLK);
      check({29'h0, tx_bits}, {29'h0, c});
      check({29'h0, rx_bits}, {29'h0, ~c});
      check({27'h0, TX_SLOT}, m ? {27'h0, s} : 32'h0);
      check({27'h0, RX_SLOT}, m ? 32'h0 : {27'h0, r});
      check({31'h0, PREADY}, 32'h0);
      repeat (1100) @(posedge REF_CLK);
      apb(1'b0, tn, 32'h0, {24'h0, tx_o[s], 1'b0});
      apb(1'b0, rn, 32'h0, {24'h0, rx_o[r], 1'b0});
      apb(1'b1, tn, $urandom, 33'h0);
      apb(1'b1, rn, $urandom, 33'h0);
      apb(1'b0, tn, 32'h0, {24'h0, tx_o[s], 1'b0});
      apb(1'b0, rn, 32'h0, {24'h0, rx_o[r], 1'b0});
    end
    apb(1'b0, 8'h5C, 32'h0, 33'h1);
    apb(1'b0, {IDX_TX_SEL, 2'b01}, 32'h0, 33'h1);
    apb(1'b1, 8'h04, 32'hFF, 33'h1);
    PSTRB <= 4'h0;
    apb(1'b1, ts, 32'hFF, 33'h0);
    PSTRB <= 4'hF;
    apb(1'b0, ts, 32'h0, {24'h0, c, s, 1'b0});
    stop_test();
  end
endmodule // e1_timeslot_monitor_tb_top
